/* design/bidr_pkg.sv */
// Shared constants and types for the bus-address and soft-reset registers
//
// How it works
// RQ1: Address field bits 7:1 load strap after reset
// RQ2: Bit 0 selects strap or programmed address
// RQ3: Bit 4 pulses video-input reset, self-clears
// RQ4: Bit 1 resets all logic and registers
// RQ5: Host then sets bridge control bit 1
// RQ6: Bit 0 resets logic, keeps registers, self-clears
// RQ7: Logic reset reloads strap-derived register values
// RQ8: Logic reset also restores listed fixed registers; code only reloads the strap address field
// RQ9: Reset writes honoured only in 3.3 V mode
package bidr_pkg;

  // Register offsets
  localparam logic [7:0] OFF_OWN_ADDR = 8'h00;
  localparam logic [7:0] OFF_SOFT_RST = 8'h01;

  // Own address register layout
  localparam int ADDR_HI = 7;
  localparam int ADDR_LO = 1;
  localparam int SRC_SEL_BIT = 0;
  localparam logic SRC_SEL_RESET = 1'b0;
  localparam logic [6:0] ADDR_FIELD_RESET = 7'h00;

  // Soft reset register layout
  localparam int VID_RST_BIT = 4;
  localparam int FULL_RST_BIT = 1;
  localparam int LOGIC_RST_BIT = 0;
  localparam logic [7:0] SOFT_RST_RESET = 8'h00;

  // Serial bus framing
  localparam int RW_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [6:0] {
    BIDR_IDLE = 7'h01,
    BIDR_ADDR = 7'h02,
    BIDR_AACK = 7'h04,
    BIDR_RX   = 7'h08,
    BIDR_RACK = 7'h10,
    BIDR_TX   = 7'h20,
    BIDR_TACK = 7'h40
  } bidr_state_t;

endpackage

/* design/bidr_i2c_slave.sv */
// Serial control bus slave: address match, offset pointer, byte transfers
module bidr_i2c_slave (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  output logic sda_oe_n, // Low while pulling data low
  input wire logic [6:0] own_address, // Address to answer
  output logic wr_stb, // One-cycle register write
  output logic [7:0] wr_offset, // Write offset
  output logic [7:0] wr_data, // Write data
  output logic [7:0] rd_offset, // Current read offset
  input wire logic [7:0] rd_data // Data at rd_offset
);

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_s;
  logic sda_s;
  logic scl_p;
  logic sda_p;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic rw;
  logic first_byte;
  logic nack;
  bidr_pkg::bidr_state_t state;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, level taken once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_s <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_s <= sda_sync[2];
      end
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_cond = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_cond = scl_s & scl_p & ~sda_p & sda_s;

  //////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= bidr_pkg::BIDR_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      rw <= 1'b0;
      first_byte <= 1'b0;
      nack <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
      wr_offset <= 8'h00;
      wr_data <= 8'h00;
      rd_offset <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        state <= bidr_pkg::BIDR_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state <= bidr_pkg::BIDR_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (state)
          bidr_pkg::BIDR_IDLE: begin
          end
          bidr_pkg::BIDR_ADDR, bidr_pkg::BIDR_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == bidr_pkg::BYTE_BITS) begin
              if (state == bidr_pkg::BIDR_ADDR) begin
                if (shreg[7:1] == own_address) begin
                  rw <= shreg[bidr_pkg::RW_BIT];
                  first_byte <= ~shreg[bidr_pkg::RW_BIT];
                  sda_oe_n <= 1'b0;
                  state <= bidr_pkg::BIDR_AACK;
                end else begin
                  state <= bidr_pkg::BIDR_IDLE;
                end
              end else begin
                sda_oe_n <= 1'b0;
                state <= bidr_pkg::BIDR_RACK;
                first_byte <= 1'b0;
                if (first_byte) begin
                  rd_offset <= shreg;
                end else begin
                  wr_stb <= 1'b1;
                  wr_offset <= rd_offset;
                  wr_data <= shreg;
                  rd_offset <= rd_offset + 8'h01;
                end
              end
            end
          end
          bidr_pkg::BIDR_AACK, bidr_pkg::BIDR_RACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw) begin
                shreg <= rd_data;
                sda_oe_n <= rd_data[7];
                state <= bidr_pkg::BIDR_TX;
              end else begin
                sda_oe_n <= 1'b1;
                state <= bidr_pkg::BIDR_RX;
              end
            end
          end
          bidr_pkg::BIDR_TX: begin
            if (scl_fall) begin
              if (bit_cnt == bidr_pkg::LAST_TX_BIT) begin
                sda_oe_n <= 1'b1;
                rd_offset <= rd_offset + 8'h01;
                state <= bidr_pkg::BIDR_TACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe_n <= shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          bidr_pkg::BIDR_TACK: begin
            if (scl_rise) begin
              nack <= sda_s;
            end else if (scl_fall) begin
              if (nack) begin
                state <= bidr_pkg::BIDR_IDLE;
              end else begin
                shreg <= rd_data;
                sda_oe_n <= rd_data[7];
                bit_cnt <= 4'h0;
                state <= bidr_pkg::BIDR_TX;
              end
            end
          end
          default: state <= bidr_pkg::BIDR_IDLE;
        endcase
      end
    end
  end

endmodule

/* design/bidr_regs.sv */
// Own bus address and soft reset registers behind the serial control bus
module bidr_regs (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rstn, // Power-on reset, async, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin, input side
  output logic sda_o, // Bus data pin, output side
  output logic sda_oe_n, // Low while driving data pin
  input wire logic [6:0] address_strap_pin, // Decoded strap address
  input wire logic io_3v3_mode, // Bus runs 3.3 V signalling
  output logic [6:0] own_address, // Address in use
  output logic video_in_reset, // Pulse resets video input
  output logic logic_only_reset, // Pulse resets logic
  output logic full_logic_and_register_reset // Pulse resets all
);

  logic [2:0] mode_sync;
  logic mode_3v3;
  logic [6:0] own_bus_address_field;
  logic address_source_select;
  logic [6:0] strap_value;
  logic strap_pending;
  logic vid_bit;
  logic full_bit;
  logic logic_bit;
  logic [7:0] rd_data;
  logic wr_stb;
  logic [7:0] wr_offset;
  logic [7:0] wr_data;
  logic [7:0] rd_offset;
  logic slave_oe_n;

  //////////////////////////////////////////////////////////////////////////
  // Bus slave
  bidr_i2c_slave u_slave (
    .clk(clk),
    .rstn(rstn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_n(slave_oe_n),
    .own_address(own_address),
    .wr_stb(wr_stb),
    .wr_offset(wr_offset),
    .wr_data(wr_data),
    .rd_offset(rd_offset),
    .rd_data(rd_data)
  );

  wire wr_addr_reg = wr_stb && wr_offset == bidr_pkg::OFF_OWN_ADDR;
  wire wr_rst_reg = wr_stb && wr_offset == bidr_pkg::OFF_SOFT_RST
    && mode_3v3; // RQ9

  //////////////////////////////////////////////////////////////////////////
  // Signalling mode pin synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_sync <= 3'h0;
      mode_3v3 <= 1'b0;
    end else begin
      mode_sync <= {mode_sync[1:0], io_3v3_mode};
      if (mode_sync[1] == mode_sync[2]) begin
        mode_3v3 <= mode_sync[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release and after the full or logic soft reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_pending <= 1'b1;
      strap_value <= bidr_pkg::ADDR_FIELD_RESET;
    end else begin
      if (strap_pending) begin
        strap_value <= address_strap_pin; // RQ1
      end
      strap_pending <= full_bit | logic_bit; // RQ7
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Own address register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      own_bus_address_field <= bidr_pkg::ADDR_FIELD_RESET;
      address_source_select <= bidr_pkg::SRC_SEL_RESET;
    end else if (full_bit) begin
      own_bus_address_field <= bidr_pkg::ADDR_FIELD_RESET; // RQ4
      address_source_select <= bidr_pkg::SRC_SEL_RESET; // RQ4
    end else if (strap_pending) begin
      own_bus_address_field <= address_strap_pin; // RQ1 RQ7
    end else if (wr_addr_reg) begin
      own_bus_address_field <= wr_data[bidr_pkg::ADDR_HI:bidr_pkg::ADDR_LO];
      address_source_select <= wr_data[bidr_pkg::SRC_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      own_address <= bidr_pkg::ADDR_FIELD_RESET;
    end else if (address_source_select) begin
      own_address <= own_bus_address_field; // RQ2
    end else begin
      own_address <= strap_value; // RQ2
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Self-clearing soft reset bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vid_bit <= bidr_pkg::SOFT_RST_RESET[bidr_pkg::VID_RST_BIT];
      full_bit <= bidr_pkg::SOFT_RST_RESET[bidr_pkg::FULL_RST_BIT];
      logic_bit <= bidr_pkg::SOFT_RST_RESET[bidr_pkg::LOGIC_RST_BIT];
    end else begin
      vid_bit <= wr_rst_reg && wr_data[bidr_pkg::VID_RST_BIT]; // RQ3
      full_bit <= wr_rst_reg && wr_data[bidr_pkg::FULL_RST_BIT]; // RQ4
      logic_bit <= wr_rst_reg && wr_data[bidr_pkg::LOGIC_RST_BIT]; // RQ6
    end
  end

  // Pulses to the rest of the chip; logic reset only reloads the strap address here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      video_in_reset <= 1'b0;
      logic_only_reset <= 1'b0;
      full_logic_and_register_reset <= 1'b0;
    end else begin
      video_in_reset <= vid_bit; // RQ3
      logic_only_reset <= logic_bit; // RQ6 RQ8
      full_logic_and_register_reset <= full_bit; // RQ4
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data and pin drive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= bidr_pkg::UNMAPPED_READ;
    end else if (rd_offset == bidr_pkg::OFF_OWN_ADDR) begin
      rd_data <= {own_bus_address_field, address_source_select};
    end else if (rd_offset == bidr_pkg::OFF_SOFT_RST) begin
      rd_data <= bidr_pkg::SOFT_RST_RESET; // RQ4 RQ6
    end else begin
      rd_data <= bidr_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= slave_oe_n;
    end
  end

endmodule

/* dv/bidr_regs_properties.sv */
// Checker for the bus address and soft reset registers
module bidr_regs_properties (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Bus data
  input wire logic sda_o, // Data out
  input wire logic sda_oe_n, // Data enable
  input wire logic [6:0] address_strap_pin, // Strap
  input wire logic io_3v3_mode, // 3.3 V mode
  input wire logic [6:0] own_address, // Address used
  input wire logic video_in_reset, // Video reset
  input wire logic logic_only_reset, // Logic reset
  input wire logic full_logic_and_register_reset // Full reset
);
  timeunit 1ns;
  timeprecision 100ps;
  logic any_rst;
  assign any_rst = video_in_reset | logic_only_reset |
    full_logic_and_register_reset;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////
  strap_load_a: assert property (
    $rose(rstn) |-> ##[1:3] own_address == address_strap_pin
  ) else $error("address not loaded from strap");
  addr_write_a: assert property (
    $changed(own_address) && $past(rstn, 4) |-> !scl_i
  ) else $error("address changed outside a bus write");
  video_pulse_a: assert property (
    video_in_reset |=> !video_in_reset
  ) else $error("video reset not one cycle");
  full_pulse_a: assert property (
    full_logic_and_register_reset |=> !full_logic_and_register_reset
  ) else $error("full reset not one cycle");
  full_strap_a: assert property (
    full_logic_and_register_reset |-> ##[0:4]
      own_address == address_strap_pin
  ) else $error("full reset kept programmed address");
  logic_pulse_a: assert property (
    logic_only_reset |=> !logic_only_reset
  ) else $error("logic reset not one cycle");
  logic_strap_a: assert property (
    logic_only_reset |-> ##[0:4] own_address == address_strap_pin
  ) else $error("logic reset did not reload strap");
  low_io_quiet_a: assert property (
    !io_3v3_mode [*8] |-> !any_rst
  ) else $error("soft reset while not in 3.3 V mode");
endmodule

bind bidr_regs bidr_regs_properties u_bidr_regs_properties (
  .clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .address_strap_pin(address_strap_pin),
  .io_3v3_mode(io_3v3_mode), .own_address(own_address),
  .video_in_reset(video_in_reset), .logic_only_reset(logic_only_reset),
  .full_logic_and_register_reset(full_logic_and_register_reset));

/* dv/bidr_host.sv */
// Serial control bus host model
module bidr_host (
  input wire logic clk, // Clock
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock
  output logic sda_pull // High pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves mid low phase, sampled at end of high phase
  task automatic bit_xfer(input logic b, output logic r);
    wait_clk(8);
    sda_pull = ~b;
    wait_clk(12);
    scl = 1'b1;
    wait_clk(20);
    r = sda;
    scl = 1'b0;
  endtask
  // Start when a=0 b=1, stop when a=1 b=0
  task automatic edge_cond(input logic a, input logic b);
    wait_clk(8);
    sda_pull = a;
    wait_clk(12);
    scl = 1'b1;
    wait_clk(20);
    sda_pull = b;
    wait_clk(20);
    scl = ~b;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], a);
      q[i] = a;
    end
    bit_xfer(1'b1, a);
    ack = ~a;
  endtask
  // Offset write, then one data byte or one read byte ending in NACK
  task automatic xfer(input logic [6:0] a, input logic [7:0] o,
    input logic [7:0] d, input logic is_rd, output logic [7:0] q,
    output logic ok);
    logic k0, k1, k2;
    edge_cond(1'b0, 1'b1);
    xbyte({a, 1'b0}, q, k0);
    xbyte(o, q, k1);
    if (is_rd) begin
      edge_cond(1'b0, 1'b1);
      xbyte({a, 1'b1}, q, k2);
    end
    xbyte(is_rd ? 8'hff : d, q, ok);
    ok = k0 & k1 & (is_rd ? k2 : ok);
    edge_cond(1'b1, 1'b0);
  endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the address and soft reset registers
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] STRAP_A = 7'h3a;
  localparam logic [6:0] STRAP_B = 7'h5d;
  localparam logic [6:0] PROG = 7'h6b;
  logic clk, rstn, scl, sda_pull, sda, sda_o, sda_oe_n, io_3v3_mode;
  logic video_in_reset, logic_only_reset, full_logic_and_register_reset;
  logic [6:0] strap, own_address;
  logic [7:0] q;
  logic ok;
  int n_errors = 0;
  int tests_run = 0;
  int n_vid = 0;
  int n_log = 0;
  int n_full = 0;
  // Open-drain line with pull-up
  assign sda = ~(sda_pull | (~sda_oe_n & ~sda_o));
  bidr_host u_bidr_host (.clk(clk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));
  bidr_regs u_bidr_regs (.clk(clk), .rstn(rstn), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .address_strap_pin(strap), .io_3v3_mode(io_3v3_mode),
    .own_address(own_address), .video_in_reset(video_in_reset),
    .logic_only_reset(logic_only_reset),
    .full_logic_and_register_reset(full_logic_and_register_reset));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (video_in_reset === 1'b1) n_vid <= n_vid + 1;
    if (logic_only_reset === 1'b1) n_log <= n_log + 1;
    if (full_logic_and_register_reset === 1'b1) n_full <= n_full + 1;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset register write; exp packs pulse counts {vid, full, logic}
  task automatic soft_wr(input logic [6:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    int v, f, l;
    v = n_vid;
    f = n_full;
    l = n_log;
    u_bidr_host.xfer(a, 8'h01, d, 1'b0, q, ok);
    check({2'h0, 2'(n_vid - v), 2'(n_full - f), 2'(n_log - l)}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    check({1'b0, own_address}, {1'b0, STRAP_A});
    u_bidr_host.xfer(STRAP_A, 8'h00, 8'h00, 1'b1, q, ok);
    check(q, {STRAP_A, 1'b0});
    u_bidr_host.xfer(STRAP_A, 8'h01, 8'h00, 1'b1, q, ok);
    check(q, 8'h00);
    u_bidr_host.xfer(STRAP_A, 8'h10, 8'h00, 1'b1, q, ok);
    check({q[7:1], ok}, 8'h01);
    $display("reset values test done");
  endtask
  task automatic t_select();
    u_bidr_host.xfer(STRAP_A, 8'h00, {PROG, 1'b1}, 1'b0, q, ok);
    check({1'b0, own_address}, {1'b0, PROG});
    u_bidr_host.xfer(STRAP_A, 8'h00, 8'h00, 1'b1, q, ok);
    check({7'h00, ok}, 8'h00);
    u_bidr_host.xfer(PROG, 8'h00, 8'h00, 1'b1, q, ok);
    check(q, {PROG, 1'b1});
    $display("address select test done");
  endtask
  task automatic t_video();
    soft_wr(PROG, 8'h10, 8'h10);
    soft_wr(PROG, 8'h00, 8'h00);
    u_bidr_host.xfer(PROG, 8'h01, 8'h00, 1'b1, q, ok);
    check(q, 8'h00);
    $display("video reset test done");
  endtask
  task automatic t_logic();
    @(posedge clk);
    #1 strap = STRAP_B;
    soft_wr(PROG, 8'h01, 8'h01);
    check({1'b0, own_address}, {1'b0, STRAP_B});
    u_bidr_host.xfer(STRAP_B, 8'h00, 8'h00, 1'b1, q, ok);
    check(q, {STRAP_B, 1'b1});
    $display("logic reset test done");
  endtask
  task automatic t_full();
    u_bidr_host.xfer(STRAP_B, 8'h00, {PROG, 1'b1}, 1'b0, q, ok);
    @(posedge clk);
    #1 strap = STRAP_A;
    soft_wr(PROG, 8'h02, 8'h04);
    u_bidr_host.xfer(STRAP_A, 8'h00, 8'h00, 1'b1, q, ok);
    check(q, {STRAP_A, 1'b0});
    u_bidr_host.xfer(STRAP_A, 8'h4f, 8'h02, 1'b0, q, ok);
    check({7'h00, ok}, 8'h01);
    $display("full reset test done");
  endtask
  task automatic t_low_io();
    @(posedge clk);
    #1 io_3v3_mode = 1'b0;
    soft_wr(STRAP_A, 8'h13, 8'h00);
    @(posedge clk);
    #1 io_3v3_mode = 1'b1;
    soft_wr(STRAP_A, 8'h10, 8'h10);
    $display("low voltage mode test done");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    io_3v3_mode = 1'b1;
    strap = STRAP_A;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge clk);
    t_reset_values();
    t_select();
    t_video();
    t_logic();
    t_full();
    t_low_io();
    complete_run();
  end
  initial begin
    #800us;
    n_errors++;
    complete_run();
  end
endmodule
